// File: hdl/lpwm_pkg.sv
// constants, register map and carrier types of the led pwm controller
package lpwm_pkg;
  localparam int NCH   = 16;
  localparam int NTM   = 8;
  localparam int GRPCH = 8;
  localparam int GRPTM = 4;
  localparam int CW    = 20;
  localparam int DW    = 25;
  localparam int FW    = 4;
  localparam int DIVW  = 18;
  localparam int AW    = 9;
  localparam int IW    = NTM + NCH;
  // divider unity step: one source tick in 8-bit fraction units
  localparam logic [DIVW:0] DIV_ONE = 19'h0_0100;
  // register map: channel c at c*16, timer t at 0x100+t*8
  localparam logic [AW-1:0] CH_STRIDE  = 9'h010;
  localparam logic [AW-1:0] TM_BASE    = 9'h100;
  localparam logic [AW-1:0] TM_STRIDE  = 9'h008;
  localparam logic [AW-1:0] VAL_BASE   = 9'h180;
  localparam logic [AW-1:0] GCONF_ADDR = 9'h1c0;
  localparam logic [AW-1:0] IRAW_ADDR  = 9'h1c4;
  localparam logic [AW-1:0] IENA_ADDR  = 9'h1c8;
  localparam logic [AW-1:0] CH_CONF    = 9'h000;
  localparam logic [AW-1:0] CH_HPOINT  = 9'h004;
  localparam logic [AW-1:0] CH_DUTY    = 9'h008;
  localparam logic [AW-1:0] CH_FADE    = 9'h00c;
  localparam logic [AW-1:0] TM_CONF    = 9'h000;
  localparam logic [AW-1:0] TM_LIM     = 9'h004;
  localparam logic [AW-1:0] CH_MASK    = 9'h1f0;
  localparam logic [AW-1:0] TM_MASK    = 9'h1f8;
  localparam logic [AW-1:0] VAL_MASK   = 9'h1e0;
  // reset values
  localparam logic [DIVW-1:0] DIV_RST = 18'h0_0100;
  localparam logic [CW-1:0]   LIM_RST = 20'h0_00ff;
  typedef struct packed {
    logic       start;
    logic       inc;
    logic [9:0] num;
    logic [9:0] cycle;
    logic [9:0] scale;
  } lpwm_fade_s;
  typedef struct packed {
    logic [9:0]      pad;
    logic            upd;
    logic            src;
    logic            rst;
    logic            pause;
    logic [DIVW-1:0] div;
  } lpwm_tconf_s;
  typedef enum logic [1:0] {
    FADE_IDLE = 2'b01,
    FADE_RUN  = 2'b10
  } lpwm_fade_e;
endpackage

// File: hdl/lpwm_top.sv
// sixteen channel led pwm controller with timers, fades and interrupts

module lpwm_top (
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  input  wire logic                    refTick,
  input  wire logic                    rc8mTick,
  input  wire logic [lpwm_pkg::AW-1:0] regAddr,
  input  wire logic [31:0]             regWdata,
  input  wire logic                    regWr,
  input  wire logic                    regRd,
  output logic      [31:0]             regRdata,
  output logic      [lpwm_pkg::NCH-1:0] pwmOut,
  output logic                         irq
);
  localparam int CW = lpwm_pkg::CW;
  localparam int DW = lpwm_pkg::DW;
  localparam int FW = lpwm_pkg::FW;

  logic [CW-1:0]              tmCnt   [lpwm_pkg::NTM];
  logic [CW-1:0]              tmLim   [lpwm_pkg::NTM];
  lpwm_pkg::lpwm_tconf_s      tmConf  [lpwm_pkg::NTM];
  logic [lpwm_pkg::NTM-1:0]   tmOvf;
  logic [1:0]                 chSel   [lpwm_pkg::NCH];
  logic [CW-1:0]              chHp    [lpwm_pkg::NCH];
  logic [DW-1:0]              chDuty  [lpwm_pkg::NCH];
  lpwm_pkg::lpwm_fade_s       chFade  [lpwm_pkg::NCH];
  logic [lpwm_pkg::NCH-1:0]   fadeDone;
  logic                       slowSelReg;
  logic [lpwm_pkg::IW-1:0]    intRawReg;
  logic [lpwm_pkg::IW-1:0]    intEnaReg;
  logic [31:0]                rdNext;
  logic                       slowTick;

  // tick inputs are enables from this clock: no synchroniser needed
  // slow clock: bus clock (every cycle) or the 8 MHz enable
  assign slowTick = slowSelReg | rc8mTick;

  // ---------------- timers ----------------
  for (genvar t = 0; t < lpwm_pkg::NTM; t++) begin : gTimer
    localparam bit FAST = (t < lpwm_pkg::GRPTM);
    localparam logic [lpwm_pkg::AW-1:0] BASE =
      lpwm_pkg::TM_BASE + lpwm_pkg::AW'(t) * lpwm_pkg::TM_STRIDE;
    lpwm_pkg::lpwm_tconf_s        confReg;
    lpwm_pkg::lpwm_tconf_s        confWr;
    logic [CW-1:0]                limReg;
    logic [CW-1:0]                limActReg;
    logic [lpwm_pkg::DIVW-1:0]    divActReg;
    logic [lpwm_pkg::DIVW:0]      accReg;
    logic [CW-1:0]                cntReg;
    logic [lpwm_pkg::DIVW:0]      accSum;
    logic [lpwm_pkg::DIVW:0]      divEff;
    logic                         srcTick;
    logic                         cntTick;
    logic                         ovf;
    logic                         updPulse;
    logic                         wrConf;
    logic                         wrLim;

    assign wrConf = regWr && regAddr == BASE + lpwm_pkg::TM_CONF;
    assign wrLim  = regWr && regAddr == BASE + lpwm_pkg::TM_LIM;
    assign confWr   = regWdata;
    assign updPulse = wrConf && confWr.upd;

    if (FAST) begin : gFastSrc
      assign srcTick = confReg.src | refTick;
    end else begin : gSlowSrc
      assign srcTick = confReg.src ? slowTick : refTick;
    end

    // factors below 1.0 behave as 1.0: one count per source tick at most
    assign divEff = (divActReg < lpwm_pkg::DIV_ONE[lpwm_pkg::DIVW-1:0]) ?
                    lpwm_pkg::DIV_ONE : {1'b0, divActReg};
    assign accSum = accReg + lpwm_pkg::DIV_ONE;
    assign cntTick = srcTick && !confReg.pause && !confReg.rst &&
                     accSum >= divEff;
    // >= keeps a lowered limit from letting the counter run to wrap
    assign ovf = cntTick && cntReg >= limActReg;

    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        confReg <= '0;
        confReg.div <= lpwm_pkg::DIV_RST;
        limReg <= lpwm_pkg::LIM_RST;
      end else begin
        if (wrConf) begin
          confReg <= regWdata;
          confReg.upd <= 1'b0;
          confReg.pad <= '0;
        end
        if (wrLim) begin
          limReg <= regWdata[CW-1:0];
        end
      end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        limActReg <= lpwm_pkg::LIM_RST;
        divActReg <= lpwm_pkg::DIV_RST;
      end else if (FAST ? (ovf || confReg.rst) : updPulse) begin
        limActReg <= limReg;
        // a slow update write carries the divider it applies
        divActReg <= FAST ? confReg.div : confWr.div;
      end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        accReg <= '0;
      end else if (confReg.rst) begin
        accReg <= '0;
      end else if (srcTick && !confReg.pause) begin
        accReg <= cntTick ? accSum - divEff : accSum;
      end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        cntReg <= '0;
      end else if (confReg.rst) begin
        cntReg <= '0;
      end else if (cntTick) begin
        cntReg <= ovf ? '0 : cntReg + 1'b1;
      end
    end

    assign tmCnt[t]  = cntReg;
    assign tmLim[t]  = limReg;
    assign tmConf[t] = confReg;
    assign tmOvf[t]  = ovf;
  end

  // ---------------- channels ----------------
  for (genvar c = 0; c < lpwm_pkg::NCH; c++) begin : gChan
    localparam logic GRP = (c >= lpwm_pkg::GRPCH);
    localparam logic [lpwm_pkg::AW-1:0] BASE =
      lpwm_pkg::AW'(c) * lpwm_pkg::CH_STRIDE;
    logic [1:0]            selReg;
    logic [CW-1:0]         hpReg;
    logic [DW-1:0]         dutyReg;
    lpwm_pkg::lpwm_fade_s  fadeReg;
    lpwm_pkg::lpwm_fade_s  fadeWr;
    lpwm_pkg::lpwm_fade_e  stateReg;
    logic [9:0]            cycCntReg;
    logic [9:0]            numCntReg;
    logic [FW-1:0]         ditAccReg;
    logic                  extReg;
    logic                  outReg;
    logic                  doneReg;
    logic [2:0]            tIdx;
    logic [CW-1:0]         cnt;
    logic                  per;
    logic [CW-1:0]         lowPt;
    logic [FW:0]           ditSum;
    logic [DW-FW:0]        incSum;
    logic [DW-FW-1:0]      dutyInt;
    logic [DW-FW-1:0]      stepped;
    logic                  wrConf;
    logic                  wrHp;
    logic                  wrDuty;
    logic                  wrFade;

    assign wrConf = regWr && regAddr == BASE + lpwm_pkg::CH_CONF;
    assign wrHp   = regWr && regAddr == BASE + lpwm_pkg::CH_HPOINT;
    assign wrDuty = regWr && regAddr == BASE + lpwm_pkg::CH_DUTY;
    assign wrFade = regWr && regAddr == BASE + lpwm_pkg::CH_FADE;
    assign fadeWr = regWdata;

    assign tIdx = {GRP, selReg};
    assign cnt  = tmCnt[tIdx];
    assign per  = tmOvf[tIdx];
    assign dutyInt = dutyReg[DW-1:FW];
    // a fraction carry stretches the next high pulse by one count
    assign lowPt = CW'(hpReg + dutyInt + extReg);
    assign ditSum = ditAccReg + dutyReg[FW-1:0];
    assign incSum = dutyInt + fadeReg.scale;
    // fade steps saturate rather than wrap
    always_comb begin
      if (fadeReg.inc) begin
        stepped = incSum[DW-FW] ? '1 : incSum[DW-FW-1:0];
      end else begin
        stepped = (dutyInt < fadeReg.scale) ? '0 : dutyInt - fadeReg.scale;
      end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        selReg <= '0;
        hpReg  <= '0;
      end else begin
        if (wrConf) begin
          selReg <= regWdata[1:0];
        end
        if (wrHp) begin
          hpReg <= regWdata[CW-1:0];
        end
      end
    end

    // low wins when both points coincide, so zero duty stays low
    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        outReg <= 1'b0;
      end else if (cnt == lowPt) begin
        outReg <= 1'b0;
      end else if (cnt == hpReg) begin
        outReg <= 1'b1;
      end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        ditAccReg <= '0;
        extReg    <= 1'b0;
      end else if (per) begin
        ditAccReg <= ditSum[FW-1:0];
        extReg    <= ditSum[FW];
      end
    end

    // software duty write overrides a fade step in the same cycle
    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        dutyReg   <= '0;
        fadeReg   <= '0;
        stateReg  <= lpwm_pkg::FADE_IDLE;
        cycCntReg <= '0;
        numCntReg <= '0;
        doneReg   <= 1'b0;
      end else begin
        doneReg <= 1'b0;
        if (wrFade) begin
          fadeReg <= regWdata;
          fadeReg.start <= 1'b0;
        end
        unique case (stateReg)
          lpwm_pkg::FADE_IDLE: begin
            if (wrFade && fadeWr.start) begin
              stateReg  <= lpwm_pkg::FADE_RUN;
              cycCntReg <= '0;
              numCntReg <= '0;
            end
          end
          lpwm_pkg::FADE_RUN: begin
            if (per) begin
              if (cycCntReg + 1'b1 >= fadeReg.cycle) begin
                cycCntReg <= '0;
                dutyReg[DW-1:FW] <= stepped;
                numCntReg <= numCntReg + 1'b1;
                if (numCntReg + 1'b1 >= fadeReg.num) begin
                  stateReg <= lpwm_pkg::FADE_IDLE;
                  doneReg  <= 1'b1;
                end
              end else begin
                cycCntReg <= cycCntReg + 1'b1;
              end
            end
          end
        endcase
        if (wrDuty) begin
          dutyReg <= regWdata[DW-1:0];
        end
      end
    end

    assign pwmOut[c]   = outReg;
    assign fadeDone[c] = doneReg;
    assign chSel[c]    = selReg;
    assign chHp[c]     = hpReg;
    assign chDuty[c]   = dutyReg;
    always_comb begin
      chFade[c] = fadeReg;
      chFade[c].start = (stateReg == lpwm_pkg::FADE_RUN);
    end
  end

  // ---------------- globals and interrupts ----------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      slowSelReg <= 1'b0;
      intEnaReg  <= '0;
    end else begin
      if (regWr && regAddr == lpwm_pkg::GCONF_ADDR) begin
        slowSelReg <= regWdata[0];
      end
      if (regWr && regAddr == lpwm_pkg::IENA_ADDR) begin
        intEnaReg <= regWdata[lpwm_pkg::IW-1:0];
      end
    end
  end

  // fade done and overflow are one-cycle events; raw bits keep them
  // a new event in the clearing cycle keeps its bit set
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      intRawReg <= '0;
    end else begin
      intRawReg <= (intRawReg &
        ~((regWr && regAddr == lpwm_pkg::IRAW_ADDR) ?
          regWdata[lpwm_pkg::IW-1:0] : '0)) |
        {fadeDone, tmOvf};
    end
  end

  assign irq = |(intRawReg & intEnaReg);

  // ---------------- register readback ----------------
  always_comb begin
    rdNext = '0;
    // unaligned addresses and unmapped ones read zero, except 0x140-0x17f, which alias the timer registers
    if (!regAddr[lpwm_pkg::AW-1]) begin
      unique case (regAddr & ~lpwm_pkg::CH_MASK)
        lpwm_pkg::CH_CONF:   rdNext = 32'(chSel[regAddr[7:4]]);
        lpwm_pkg::CH_HPOINT: rdNext = 32'(chHp[regAddr[7:4]]);
        lpwm_pkg::CH_DUTY:   rdNext = 32'(chDuty[regAddr[7:4]]);
        lpwm_pkg::CH_FADE:   rdNext = chFade[regAddr[7:4]];
        default:             rdNext = '0;
      endcase
    end
    if ((regAddr & lpwm_pkg::VAL_MASK) >= lpwm_pkg::TM_BASE &&
        (regAddr & lpwm_pkg::VAL_MASK) < lpwm_pkg::VAL_BASE) begin
      if ((regAddr & ~lpwm_pkg::TM_MASK) == lpwm_pkg::TM_CONF) begin
        rdNext = tmConf[regAddr[5:3]];
      end else if ((regAddr & ~lpwm_pkg::TM_MASK) == lpwm_pkg::TM_LIM) begin
        rdNext = 32'(tmLim[regAddr[5:3]]);
      end
    end
    // live count: two reads may see it move
    if ((regAddr & lpwm_pkg::VAL_MASK) == lpwm_pkg::VAL_BASE &&
        regAddr[1:0] == '0) begin
      rdNext = 32'(tmCnt[regAddr[4:2]]);
    end
    if (regAddr == lpwm_pkg::GCONF_ADDR) begin
      rdNext = 32'(slowSelReg);
    end
    if (regAddr == lpwm_pkg::IRAW_ADDR) begin
      rdNext = 32'(intRawReg);
    end
    if (regAddr == lpwm_pkg::IENA_ADDR) begin
      rdNext = 32'(intEnaReg);
    end
  end

  // read data hold until the next read strobe
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= '0;
    end else if (regRd) begin
      regRdata <= rdNext;
    end
  end
endmodule

// File: verification/lpwm_top_check_assertions.sv
// checker on the led pwm controller ports
module lpwm_top_check (
  input wire logic                     clock,
  input wire logic                     sys_rst,
  input wire logic                     refTick,
  input wire logic                     rc8mTick,
  input wire logic [lpwm_pkg::AW-1:0]  regAddr,
  input wire logic [31:0]              regWdata,
  input wire logic                     regWr,
  input wire logic                     regRd,
  input wire logic [31:0]              regRdata,
  input wire logic [lpwm_pkg::NCH-1:0] pwmOut,
  input wire logic                     irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  read_data_hold_a: assert property (
    !regRd |=> $stable(regRdata)) else $error("read data moved");
  unmapped_zero_a: assert property (
    regRd && regAddr == 9'h1cc |=> regRdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  enable_readback_a: assert property (
    regWr && regAddr == lpwm_pkg::IENA_ADDR ##1
    regRd && regAddr == lpwm_pkg::IENA_ADDR
    |=> regRdata == {8'h00, $past(regWdata[23:0], 2)})
    else $error("enable readback wrong");
  mask_irq_a: assert property (
    regWr && regAddr == lpwm_pkg::IENA_ADDR && regWdata == 32'h0000_0000
    |=> !irq) else $error("irq high with all sources masked");
  hpoint_readback_a: assert property (
    regWr && regAddr == 9'h004 ##1 regRd && regAddr == 9'h004
    |=> regRdata == {12'h000, $past(regWdata[19:0], 2)})
    else $error("high point readback wrong");
  limit_readback_a: assert property (
    regWr && regAddr == 9'h104 ##1 regRd && regAddr == 9'h104
    |=> regRdata == {12'h000, $past(regWdata[19:0], 2)})
    else $error("limit readback wrong");
  param_upd_zero_a: assert property (
    regRd && regAddr == 9'h128 |=> regRdata[21] == 1'b0)
    else $error("update bit reads one");
  duty_readback_a: assert property (
    regWr && regAddr == 9'h088 ##1 regRd && regAddr == 9'h088
    |=> regRdata == {7'h00, $past(regWdata[24:0], 2)})
    else $error("duty readback wrong");
endmodule
bind lpwm_top lpwm_top_check i_chk (
  .clock(clock), .sys_rst(sys_rst), .refTick(refTick),
  .rc8mTick(rc8mTick), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .pwmOut(pwmOut), .irq(irq));

// File: verification/lpwm_led_load.sv
// led load model counting high cycles and rising edges of one channel
module lpwm_led_load #(parameter int CH = 0) (
  input  wire logic                     clock,
  input  wire logic                     clr,
  input  wire logic [lpwm_pkg::NCH-1:0] pwmOut,
  output logic      [15:0]              highCnt,
  output logic      [15:0]              riseCnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prevLvl;
  // passive load: samples the level only, never drives back
  always_ff @(posedge clock) begin
    prevLvl <= pwmOut[CH];
    if (clr) begin
      highCnt <= 16'h0000;
      riseCnt <= 16'h0000;
    end else begin
      highCnt <= highCnt + 16'(pwmOut[CH]);
      riseCnt <= riseCnt + 16'(pwmOut[CH] & !prevLvl);
    end
  end
endmodule

// File: verification/tb_led_pwm_controller.sv
// register level testbench of the led pwm controller
module tb_led_pwm_controller;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0;
  logic        sys_rst = 1;
  logic        refTick = 0;
  logic        rc8mTick = 0;
  logic [8:0]  regAddr = 9'h000;
  logic [31:0] regWdata = 32'h0000_0000;
  logic        regWr = 0;
  logic        regRd = 0;
  logic [31:0] regRdata;
  logic [15:0] pwmOut;
  logic        irq;
  logic        clr = 0;
  logic [15:0] hi0, ri0, hi8, ri8;
  logic [31:0] v1, v2;
  logic [7:0]  tk = 8'h00;
  int          errors = 0;
  int          numChecks = 0;
  logic [31:0] fadeW [2] = '{32'hc020_0401, 32'h8010_0402};
  logic [31:0] fadeE [2] = '{32'h0000_0050, 32'h0000_0030};
  always #5 clock = ~clock;
  // tick sources run free; phase against the timers is arbitrary
  always @(posedge clock) begin
    tk <= (tk == 8'h09) ? 8'h00 : tk + 8'h01;
    refTick <= (tk % 5 == 0);
    rc8mTick <= (tk % 10 == 0);
  end
  lpwm_top i_dut (.clock(clock), .sys_rst(sys_rst), .refTick(refTick),
    .rc8mTick(rc8mTick), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .pwmOut(pwmOut), .irq(irq));
  lpwm_led_load #(.CH(0)) i_led0 (.clock(clock), .clr(clr),
    .pwmOut(pwmOut), .highCnt(hi0), .riseCnt(ri0));
  lpwm_led_load #(.CH(8)) i_led8 (.clock(clock), .clr(clr),
    .pwmOut(pwmOut), .highCnt(hi8), .riseCnt(ri8));
  task automatic chk(input string n, input logic [31:0] s, e);
    numChecks++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // write strobe is held between back to back writes, lowered by rd/idle
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1;
    regRd <= 0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [8:0] a, output logic [31:0] d);
    regAddr <= a;
    regRd <= 1;
    regWr <= 0;
    @(posedge clock);
    regRd <= 0;
    #1 d = regRdata;
    @(posedge clock);
  endtask
  task automatic idle(input int n);
    regWr <= 0;
    repeat (n) @(posedge clock);
  endtask
  task automatic window(input int n);
    clr <= 1;
    @(posedge clock);
    clr <= 0;
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    report_and_stop;
  end
  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 0;
    @(posedge clock);
    rd(9'h100, v1); chk("tconf rst", v1, 32'h0000_0100);
    rd(9'h104, v1); chk("limit rst", v1, 32'h0000_00ff);
    rd(9'h1cc, v1); chk("unmapped", v1, 32'h0000_0000);
    wr(9'h1c8, 32'h00ff_ffff);
    rd(9'h1c8, v1);
    // fast timer 0: limit 7, bus clock, shadow loaded while held in reset
    wr(9'h104, 32'h0000_0007);
    rd(9'h104, v1);
    wr(9'h100, 32'h0018_0100);
    wr(9'h100, 32'h0010_0100);
    rd(9'h180, v1);
    rd(9'h180, v2);
    chk("count step", (v2 - v1) & 32'h7, 32'h0000_0002);
    wr(9'h100, 32'h0014_0100);
    rd(9'h180, v1);
    rd(9'h180, v2);
    chk("pause", v2, v1);
    wr(9'h100, 32'h0000_0100);
    rd(9'h180, v1);
    rd(9'h180, v2);
    chk("ref tick", 32'(((v2 - v1) & 32'h7) < 32'h2), 32'h1);
    wr(9'h100, 32'h0010_0100);
    // slow timer 1 of the slow group: bus clock as slow clock, limit 3
    wr(9'h1c0, 32'h0000_0001);
    wr(9'h12c, 32'h0000_0003);
    wr(9'h128, 32'h0038_0100);
    wr(9'h128, 32'h0010_0100);
    rd(9'h128, v1);
    wr(9'h000, 32'h0000_0000);
    wr(9'h004, 32'h0000_0002);
    rd(9'h004, v1);
    wr(9'h008, 32'h0000_0030);
    wr(9'h080, 32'h0000_0001);
    wr(9'h084, 32'h0000_0000);
    wr(9'h088, 32'h0000_0010);
    rd(9'h088, v1);
    idle(20);
    window(80);
    chk("ch0 high", {16'h0, hi0}, 32'h0000_001e);
    chk("ch0 rise", {16'h0, ri0}, 32'h0000_000a);
    chk("ch8 high", {16'h0, hi8}, 32'h0000_0014);
    chk("ch8 rise", {16'h0, ri8}, 32'h0000_0014);
    wr(9'h1c4, 32'h00ff_ffff);
    idle(12);
    rd(9'h1c4, v1);
    chk("ovf raw", v1 & 32'h21, 32'h0000_0021);
    wr(9'h008, 32'h0000_0038);
    idle(20);
    window(128);
    chk("dither", {16'h0, hi0}, 32'h0000_0038);
    wr(9'h008, 32'h0000_0030);
    for (int i = 0; i < 2; i++) begin
      wr(9'h1c8, 32'h0000_0100);
      wr(9'h1c4, 32'h0000_0100);
      wr(9'h00c, fadeW[i]);
      idle(100);
      rd(9'h008, v1); chk("fade duty", v1, fadeE[i]);
      rd(9'h00c, v1); chk("fade busy", {31'h0, v1[31]}, 32'h0);
      rd(9'h1c4, v1); chk("fade raw", {31'h0, v1[8]}, 32'h1);
      chk("irq on", {31'h0, irq}, 32'h1);
      wr(9'h1c8, 32'h0000_0000);
      idle(1);
      chk("irq masked", {31'h0, irq}, 32'h0);
      wr(9'h1c4, 32'h0000_0100);
      rd(9'h1c4, v1); chk("fade clr", {31'h0, v1[8]}, 32'h0);
    end
    report_and_stop;
  end
endmodule
